//--- hw/rxpm_pkg.sv
// Purpose: shared constants and types of the receive phase meter
// Assumes: mclk at 10 MHz, 13-bit signed front-end samples
// Notes: angles are kept as 12-bit turns, 16 steps per output code
`default_nettype none
package rxpm_pkg;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_HZ = 1_000_000;
  localparam int PERIOD_NS = 8000;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int SUB_CNT = PERIOD_NS / (1_000_000_000 / TICK_HZ);
  localparam int PERIOD_CYC = TICK_CYC * SUB_CNT;
  localparam logic [3:0] TICK_LAST = 4'(TICK_CYC - 1);
  localparam logic [2:0] SUB_LAST = 3'(SUB_CNT - 1);
  // word addresses
  localparam logic [2:0] ADR_CTRL = 3'h0;
  localparam logic [2:0] ADR_PHASE = 3'h1;
  localparam logic [2:0] ADR_QUAL = 3'h2;
  localparam logic [2:0] ADR_REAL = 3'h3;
  localparam logic [2:0] ADR_IMAG = 3'h4;
  // control fields
  localparam int B_ENABLE = 0;
  localparam int B_AVERAGING_SEL = 1;
  localparam int SYNC_LSB = 2;
  localparam int B_FREQ_ERR_SEL = 5;
  localparam int B_IQ_FORM_SEL = 6;
  localparam int B_CF_TIME_ALIGN = 7;
  localparam logic [7:0] CTRL_RST = 8'h02;
  localparam logic [7:0] CTRL_WMASK = 8'hE3;
  // arithmetic
  localparam int CW = 28;
  localparam int NIT = 10;
  localparam logic [3:0] IT_LAST = 4'(NIT - 1);
  localparam logic [11:0] HALF_TURN = 12'h800;
  localparam logic [11:0] ANG_RND = 12'h008;
  localparam logic signed [CW-1:0] ROT_X0 = 28'sh0002641;
  localparam logic [11:0] ATAN_TAB [NIT] = '{12'h200, 12'h12F, 12'h0A0, 12'h051,
    12'h029, 12'h014, 12'h00A, 12'h005, 12'h003, 12'h001};
  localparam int RAW_DROP = 5;
  localparam int NRM_DROP = 8;
  localparam logic signed [CW-1:0] RAW_RND = 28'sh0000010;
  localparam logic signed [CW-1:0] NRM_RND = 28'sh0000080;
  localparam logic signed [CW-1:0] SAT_HI = 28'sh000007F;
  localparam logic signed [CW-1:0] SAT_LO = -28'sh0000080;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VEC = 3'b001,
    ST_ROT = 3'b011,
    ST_DRF = 3'b010,
    ST_DONE = 3'b110
  } rxpm_state_e;
endpackage : rxpm_pkg
`default_nettype wire

//--- hw/rxpm_top.sv
// Purpose: periodic phase, I/Q and stability monitor on receiver samples
// Assumes: samples arrive on mclk with a valid strobe
// Notes: results lag the measured period by one period
//
// Chosen here: the address map and the Avalon-MM slave port.
`default_nettype none
module rxpm_top
  import rxpm_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // avalon-mm slave
  input wire logic [2:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // front-end samples
  input wire logic fe_valid_in,
  input wire logic signed [12:0] fe_i_in,
  input wire logic signed [12:0] fe_q_in,
  // channel number setting
  input wire logic chan_wr_in,
  input wire logic [7:0] chan_data_in,
  output logic chan_apply_out,
  output logic [7:0] chan_number_out
);

  function automatic logic [7:0] sat8(input logic signed [CW-1:0] v);
    if (v > SAT_HI) return 8'h7F;
    if (v < SAT_LO) return 8'h80;
    return v[7:0];
  endfunction : sat8

  // bus and control
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] res_ph_r, res_ph_nxt, res_q_r, res_q_nxt;
  logic [7:0] res_re_r, res_re_nxt, res_im_r, res_im_nxt;
  logic [2:0] sub_r, sub_nxt;
  logic en, wrap;

  assign en = ctrl_r[B_ENABLE];
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
  assign avs_readdata_out = rdata_r;

  always_comb begin
    ack_nxt = (avs_read_in | avs_write_in) & ~ack_r;
    ctrl_nxt = ctrl_r;
    if (avs_write_in && ack_r && avs_byteenable_in[0] && avs_address_in == ADR_CTRL) begin
      ctrl_nxt = avs_writedata_in[7:0] & CTRL_WMASK;
    end
    rdata_nxt = 32'h0;
    case (avs_address_in)
      ADR_CTRL: rdata_nxt[7:0] = {ctrl_r[7:5], sub_r, ctrl_r[1:0]};
      ADR_PHASE: rdata_nxt[7:0] = res_ph_r;
      ADR_QUAL: rdata_nxt[7:0] = res_q_r;
      ADR_REAL: rdata_nxt[7:0] = res_re_r;
      ADR_IMAG: rdata_nxt[7:0] = res_im_r;
      default: rdata_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      ctrl_r <= CTRL_RST;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // period timing and accumulation
  logic [3:0] tick_r, tick_nxt;
  logic [6:0] cnt_r, cnt_nxt, cnt_w;
  logic signed [19:0] aci_r, aci_nxt, acq_r, acq_nxt, aci_w, acq_w;
  logic signed [12:0] li_r, li_nxt, lq_r, lq_nxt, li_w, lq_w;
  logic signed [7:0] pi_r, pi_nxt, pq_r, pq_nxt, ci, cq;
  logic hp_r, hp_nxt;
  logic signed [23:0] dx_r, dx_nxt, dy_r, dy_nxt, dx_w, dy_w;
  logic signed [16:0] dre, dim;
  logic signed [CW-1:0] sdx_r, sdx_nxt, sdy_r, sdy_nxt, sx_w, sy_w, mi, mq;
  logic [7:0] raw_re_r, raw_re_nxt, raw_im_r, raw_im_nxt, cfg_r, cfg_nxt;
  logic [2:0] sh;
  logic aver;

  assign wrap = en && tick_r == TICK_LAST && sub_r == SUB_LAST;

  always_comb begin
    ci = fe_i_in[12:5];
    cq = fe_q_in[12:5];
    // conjugate product of consecutive samples tracks the drift
    dre = 17'(ci * pi_r) + 17'(cq * pq_r);
    dim = 17'(cq * pi_r) - 17'(ci * pq_r);
    aci_w = aci_r;
    acq_w = acq_r;
    cnt_w = cnt_r;
    li_w = li_r;
    lq_w = lq_r;
    dx_w = dx_r;
    dy_w = dy_r;
    if (fe_valid_in) begin
      aci_w = aci_r + 20'(fe_i_in);
      acq_w = acq_r + 20'(fe_q_in);
      cnt_w = cnt_r + 7'h01;
      li_w = fe_i_in;
      lq_w = fe_q_in;
      if (hp_r) begin
        dx_w = dx_r + 24'(dre);
        dy_w = dy_r + 24'(dim);
      end
    end
    // mean by shift: exact only for power-of-two sample counts
    sh = 3'h0;
    for (int k = 1; k < 7; k++) begin
      if (cnt_w[k]) sh = 3'(k);
    end
    aver = ctrl_r[B_AVERAGING_SEL];
    sx_w = aver ? CW'(aci_w) : CW'(li_w);
    sy_w = aver ? CW'(acq_w) : CW'(lq_w);
    mi = aver ? sx_w >>> sh : sx_w;
    mq = aver ? sy_w >>> sh : sy_w;
    tick_nxt = 4'h0;
    sub_nxt = 3'h0;
    cnt_nxt = 7'h00;
    aci_nxt = 20'sh0;
    acq_nxt = 20'sh0;
    dx_nxt = 24'sh0;
    dy_nxt = 24'sh0;
    li_nxt = li_w;
    lq_nxt = lq_w;
    pi_nxt = fe_valid_in ? ci : pi_r;
    pq_nxt = fe_valid_in ? cq : pq_r;
    hp_nxt = 1'b0;
    sdx_nxt = sdx_r;
    sdy_nxt = sdy_r;
    raw_re_nxt = raw_re_r;
    raw_im_nxt = raw_im_r;
    cfg_nxt = cfg_r;
    if (en) begin
      tick_nxt = (tick_r == TICK_LAST) ? 4'h0 : tick_r + 4'h1;
      sub_nxt = sub_r;
      if (tick_r == TICK_LAST) begin
        sub_nxt = (sub_r == SUB_LAST) ? 3'h0 : sub_r + 3'h1;
      end
      hp_nxt = hp_r | fe_valid_in;
      if (wrap) begin
        sdx_nxt = CW'(dx_w);
        sdy_nxt = CW'(dy_w);
        raw_re_nxt = sat8((mi + RAW_RND) >>> RAW_DROP);
        raw_im_nxt = sat8((mq + RAW_RND) >>> RAW_DROP);
        cfg_nxt = ctrl_r;
      end else begin
        cnt_nxt = cnt_w;
        aci_nxt = aci_w;
        acq_nxt = acq_w;
        dx_nxt = dx_w;
        dy_nxt = dy_w;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_r <= 4'h0;
      sub_r <= 3'h0;
      cnt_r <= 7'h00;
      aci_r <= 20'sh0;
      acq_r <= 20'sh0;
      li_r <= 13'sh0;
      lq_r <= 13'sh0;
      pi_r <= 8'sh0;
      pq_r <= 8'sh0;
      hp_r <= 1'b0;
      dx_r <= 24'sh0;
      dy_r <= 24'sh0;
      sdx_r <= '0;
      sdy_r <= '0;
      raw_re_r <= 8'h00;
      raw_im_r <= 8'h00;
      cfg_r <= 8'h00;
    end else begin
      tick_r <= tick_nxt;
      sub_r <= sub_nxt;
      cnt_r <= cnt_nxt;
      aci_r <= aci_nxt;
      acq_r <= acq_nxt;
      li_r <= li_nxt;
      lq_r <= lq_nxt;
      pi_r <= pi_nxt;
      pq_r <= pq_nxt;
      hp_r <= hp_nxt;
      dx_r <= dx_nxt;
      dy_r <= dy_nxt;
      sdx_r <= sdx_nxt;
      sdy_r <= sdy_nxt;
      raw_re_r <= raw_re_nxt;
      raw_im_r <= raw_im_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // angle engine: vector mean, rotate unit vector, vector drift
  rxpm_state_e st_r, st_nxt;
  logic [3:0] it_r, it_nxt;
  logic signed [CW-1:0] x_r, x_nxt, y_r, y_nxt, xs, ys, xi, yi, vsx, vsy;
  logic [11:0] z_r, z_nxt, zi, zr, at;
  logic [7:0] stg_ph_r, stg_ph_nxt, stg_q_r, stg_q_nxt;
  logic [7:0] stg_re_r, stg_re_nxt, stg_im_r, stg_im_nxt;
  logic stg_ok_r, stg_ok_nxt, ccw, last, rneg;
  logic signed [7:0] dph;
  logic [8:0] mag;
  logic [9:0] dbl;

  always_comb begin
    xs = x_r >>> it_r;
    ys = y_r >>> it_r;
    at = ATAN_TAB[it_r];
    ccw = (st_r == ST_ROT) ? ~z_r[11] : y_r[CW-1];
    xi = ccw ? x_r - ys : x_r + ys;
    yi = ccw ? y_r + xs : y_r - xs;
    zi = ccw ? z_r - at : z_r + at;
    zr = zi + ANG_RND;
    dph = zr[11:4];
    mag = dph[7] ? 9'h000 - 9'(dph) : 9'(dph);
    dbl = {mag, 1'b0};
    last = it_r == IT_LAST;
    rneg = zi[11] ^ zi[10];
    st_nxt = st_r;
    it_nxt = it_r + 4'h1;
    x_nxt = xi;
    y_nxt = yi;
    z_nxt = zi;
    stg_ph_nxt = stg_ph_r;
    stg_q_nxt = stg_q_r;
    stg_re_nxt = stg_re_r;
    stg_im_nxt = stg_im_r;
    stg_ok_nxt = stg_ok_r & en;
    res_ph_nxt = res_ph_r;
    res_q_nxt = res_q_r;
    res_re_nxt = res_re_r;
    res_im_nxt = res_im_r;
    unique case (st_r)
      ST_IDLE, ST_DONE: begin
        it_nxt = it_r;
        x_nxt = x_r;
        y_nxt = y_r;
        z_nxt = z_r;
      end
      ST_VEC: if (last) begin
        stg_ph_nxt = zr[11:4];
        x_nxt = rneg ? -ROT_X0 : ROT_X0;
        y_nxt = '0;
        z_nxt = rneg ? zi - HALF_TURN : zi;
        it_nxt = 4'h0;
        st_nxt = ST_ROT;
      end
      ST_ROT: if (last) begin
        stg_re_nxt = sat8((xi + NRM_RND) >>> NRM_DROP);
        stg_im_nxt = sat8((yi + NRM_RND) >>> NRM_DROP);
        st_nxt = ST_DRF;
      end
      ST_DRF: if (last) begin
        // offset code is twice the mean phase step per sample
        stg_q_nxt = cfg_r[B_FREQ_ERR_SEL] ? sat8(CW'(dph) <<< 1)
          : ((dbl > 10'h0FF) ? 8'h00 : 8'hFF - dbl[7:0]);
        if (cfg_r[B_IQ_FORM_SEL]) begin
          stg_re_nxt = raw_re_r;
          stg_im_nxt = raw_im_r;
        end
        stg_ok_nxt = 1'b1;
        it_nxt = 4'h0;
        st_nxt = ST_DONE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    vsx = wrap ? sx_w : sdx_r;
    vsy = wrap ? sy_w : sdy_r;
    if (wrap || (st_r == ST_ROT && last)) begin
      x_nxt = vsx[CW-1] ? -vsx : vsx;
      y_nxt = vsx[CW-1] ? -vsy : vsy;
      z_nxt = vsx[CW-1] ? HALF_TURN : 12'h000;
      it_nxt = 4'h0;
    end
    if (wrap) begin
      st_nxt = ST_VEC;
      stg_ok_nxt = 1'b0;
      if (stg_ok_r) begin
        res_ph_nxt = stg_ph_r;
        res_q_nxt = stg_q_r;
        res_re_nxt = stg_re_r;
        res_im_nxt = stg_im_r;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= ST_IDLE;
      it_r <= 4'h0;
      x_r <= '0;
      y_r <= '0;
      z_r <= 12'h000;
      stg_ph_r <= 8'h00;
      stg_q_r <= 8'h00;
      stg_re_r <= 8'h00;
      stg_im_r <= 8'h00;
      stg_ok_r <= 1'b0;
      res_ph_r <= 8'h00;
      res_q_r <= 8'h00;
      res_re_r <= 8'h00;
      res_im_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      it_r <= it_nxt;
      x_r <= x_nxt;
      y_r <= y_nxt;
      z_r <= z_nxt;
      stg_ph_r <= stg_ph_nxt;
      stg_q_r <= stg_q_nxt;
      stg_re_r <= stg_re_nxt;
      stg_im_r <= stg_im_nxt;
      stg_ok_r <= stg_ok_nxt;
      res_ph_r <= res_ph_nxt;
      res_q_r <= res_q_nxt;
      res_re_r <= res_re_nxt;
      res_im_r <= res_im_nxt;
    end
  end

  // channel change alignment
  logic pend_r, pend_nxt, apply_r, apply_nxt, align;
  logic [7:0] pval_r, pval_nxt, chan_r, chan_nxt;

  assign align = ctrl_r[B_CF_TIME_ALIGN] & en;
  assign chan_apply_out = apply_r;
  assign chan_number_out = chan_r;

  always_comb begin
    pend_nxt = pend_r;
    pval_nxt = pval_r;
    chan_nxt = chan_r;
    apply_nxt = 1'b0;
    if (pend_r && (wrap || !align)) begin
      chan_nxt = pval_r;
      apply_nxt = 1'b1;
      pend_nxt = 1'b0;
    end
    // with alignment off a new write wins over the release of an older one; with it on the older one is applied and the new one held
    if (chan_wr_in) begin
      if (align) begin
        pend_nxt = 1'b1;
        pval_nxt = chan_data_in;
      end else begin
        chan_nxt = chan_data_in;
        apply_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_r <= 1'b0;
      pval_r <= 8'h00;
      chan_r <= 8'h00;
      apply_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      pval_r <= pval_nxt;
      chan_r <= chan_nxt;
      apply_r <= apply_nxt;
    end
  end

  // checks
  logic [6:0] gap_r;
  logic seen_r;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_r <= 7'h00;
      seen_r <= 1'b0;
    end else begin
      gap_r <= (wrap || !en) ? 7'h00 : gap_r + 7'h01;
      seen_r <= en & (seen_r | wrap);
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  property p_period_len;
    wrap && seen_r |-> gap_r == 7'(PERIOD_CYC - 1);
  endproperty
  a_period_len: assert property (p_period_len) else $error("period length wrong");
  property p_sub_wrap;
    wrap |=> sub_r == 3'h0 ##(TICK_CYC) (sub_r == 3'h1 || !en);
  endproperty
  a_sub_wrap: assert property (p_sub_wrap) else $error("sub counter wrap wrong");
  property p_res_at_wrap;
    ($changed(res_ph_r) || $changed(res_q_r) || $changed(res_re_r) || $changed(res_im_r))
      |-> $past(wrap);
  endproperty
  a_res_at_wrap: assert property (p_res_at_wrap) else $error("result off boundary");
  property p_ctrl_reset;
    $rose(rst_n_in) |-> ctrl_r == CTRL_RST;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset value");
  property p_disabled;
    !en ##1 !en |-> sub_r == 3'h0 && tick_r == 4'h0 && $stable(res_ph_r);
  endproperty
  a_disabled: assert property (p_disabled) else $error("runs while disabled");
  property p_cf_now;
    chan_wr_in && !align |=> chan_apply_out && chan_number_out == $past(chan_data_in);
  endproperty
  a_cf_now: assert property (p_cf_now) else $error("channel not applied");
  property p_cf_aligned;
    chan_apply_out && !$past(chan_wr_in) && $past(align) |-> $past(wrap);
  endproperty
  a_cf_aligned: assert property (p_cf_aligned) else $error("channel not aligned");
  property p_sync_read;
    avs_read_in && !avs_waitrequest_out && avs_address_in == ADR_CTRL
      |-> avs_readdata_out[4:2] == $past(sub_r);
  endproperty
  a_sync_read: assert property (p_sync_read) else $error("sync field wrong");
  property p_valid_only;
    en && !wrap && !fe_valid_in |=> cnt_r == $past(cnt_r);
  endproperty
  a_valid_only: assert property (p_valid_only) else $error("invalid sample counted");

endmodule : rxpm_top
`default_nettype wire

//--- test/rxpm_fe_model.sv
// Purpose: front-end sample source for the phase meter bench
// Assumes: one sample per 10 clocks, which is 1 MHz at a 10 MHz clock
// Notes: data lines toggle between strobes so stale values never look valid
`default_nettype none
module rxpm_fe_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // base vector, rotation per sample, sign flip of i on odd samples
  input wire logic signed [12:0] base_i_in,
  input wire logic signed [12:0] base_q_in,
  input wire logic [7:0] step_in,
  input wire logic alt_in,
  // samples
  output logic valid_out,
  output logic signed [12:0] i_out,
  output logic signed [12:0] q_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_r;
  int n_r;
  real a;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 0;
      n_r <= 0;
      valid_out <= 1'b0;
      i_out <= '0;
      q_out <= '0;
    end else if (cnt_r == 9) begin
      a = 6.28318530717959 * real'(n_r * int'(step_in)) / 256.0;
      i_out <= 13'(int'(base_i_in * $cos(a) - base_q_in * $sin(a)) *
        ((alt_in && n_r[0]) ? -1 : 1));
      q_out <= 13'(int'(base_i_in * $sin(a) + base_q_in * $cos(a)));
      valid_out <= 1'b1;
      cnt_r <= 0;
      n_r <= n_r + 1;
    end else begin
      cnt_r <= cnt_r + 1;
      valid_out <= 1'b0;
      i_out <= ~i_out;
      q_out <= ~q_out;
    end
  end
endmodule : rxpm_fe_model
`default_nettype wire

//--- test/tb.sv
// Purpose: self-checking bench for the receive phase meter
// Assumes: 10 MHz clock, samples at 1 MHz from the model
// Notes: trig results may differ by one code, so those checks allow 1 LSB, and the doubled offset code checks allow 2
`default_nettype none
module tb
  import rxpm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic fe_valid_in, chan_wr_in, chan_apply_out, alt;
  logic [2:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, seed;
  logic [3:0] avs_byteenable_in;
  logic signed [12:0] fe_i_in, fe_q_in, bi, bq;
  logic [7:0] chan_data_in, chan_number_out, step, v, p, qf, re, im, keep;
  int n_mismatch, n_tests, k, e, prev, seen, ci, cq;
  real ph;

  rxpm_top DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .fe_valid_in(fe_valid_in), .fe_i_in(fe_i_in), .fe_q_in(fe_q_in),
    .chan_wr_in(chan_wr_in), .chan_data_in(chan_data_in),
    .chan_apply_out(chan_apply_out), .chan_number_out(chan_number_out));
  rxpm_fe_model FE (.clk_in(mclk_in), .rst_n_in(rst_n_in), .base_i_in(bi), .base_q_in(bq),
    .step_in(step), .alt_in(alt), .valid_out(fe_valid_in), .i_out(fe_i_in),
    .q_out(fe_q_in));

  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [7:0] got, input int exp, input int tol);
    logic [7:0] d;
    d = got - 8'(exp);
    n_tests++;
    if ((^got === 1'bx) || ($signed(d) > tol) || ($signed(d) < -tol)) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, 8'(exp));
    end
  endtask : chk

  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= {24'h000000, d};
    do begin
      @(posedge mclk_in);
    end while (avs_waitrequest_out !== 1'b0);
    // read data stand at the edge that ends the wait; a hang is left to the watchdog
    v = avs_readdata_out[7:0];
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic run(input logic [7:0] c, input int i, input int q, input int s,
    input logic al);
    bi <= 13'(i);
    bq <= 13'(q);
    step <= 8'(s);
    alt <= al;
    bus(1'b1, ADR_CTRL, c);
    // the period holding the change is never the one published
    repeat (4 * PERIOD_CYC) @(posedge mclk_in);
    bus(1'b0, ADR_PHASE, 8'h00);
    p = v;
    bus(1'b0, ADR_QUAL, 8'h00);
    qf = v;
    bus(1'b0, ADR_REAL, 8'h00);
    re = v;
    bus(1'b0, ADR_IMAG, 8'h00);
    im = v;
  endtask : run

  task automatic chan(input logic [7:0] d);
    @(posedge mclk_in);
    chan_wr_in <= 1'b1;
    chan_data_in <= d;
    @(posedge mclk_in);
    chan_wr_in <= 1'b0;
  endtask : chan

  task automatic final_report;
    $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (12000) @(posedge mclk_in);
    n_mismatch++;
    final_report();
  end

  initial begin
    rst_n_in = 1'b0;
    avs_address_in = '0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = '0;
    avs_byteenable_in = 4'hF;
    chan_wr_in = 1'b0;
    chan_data_in = '0;
    bi = '0;
    bq = '0;
    step = '0;
    alt = 1'b0;
    seed = 32'h8D2B933D;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    bus(1'b0, ADR_CTRL, 8'h00);
    chk(v, CTRL_RST, 0);
    bus(1'b0, 3'h5, 8'h00);
    chk(v, 0, 0);
    avs_byteenable_in <= 4'h0;
    bus(1'b1, ADR_CTRL, 8'hFD);
    avs_byteenable_in <= 4'hF;
    bus(1'b0, ADR_CTRL, 8'h00);
    chk(v, CTRL_RST, 0);
    bus(1'b1, ADR_CTRL, 8'hFC);
    bus(1'b0, ADR_CTRL, 8'h00);
    chk(v, 8'hE0, 0);
    // counter field must step by at most one between reads and visit every value
    bus(1'b1, ADR_CTRL, 8'h03);
    seen = 0;
    prev = 0;
    for (k = 0; k < 40; k++) begin
      bus(1'b0, ADR_CTRL, 8'h00);
      e = int'(v[4:2]);
      seen = seen | (1 << e);
      chk(8'((e - prev) & 7), 0, 1);
      prev = e;
    end
    chk(8'(seen), 8'hFF, 0);
    // random angles, raw and normalized forms in turn
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      ph = real'(seed[7:0]) * 3.14159265358979 / 128.0;
      ci = int'(1500.0 * $cos(ph));
      cq = int'(1500.0 * $sin(ph));
      run(k[0] ? 8'h03 : 8'h43, ci, cq, 0, 1'b0);
      chk(p, int'(seed[7:0]), 1);
      chk(qf, 255, 0);
      chk(re, k[0] ? int'(63.0 * $cos(ph)) : (ci + 16) >>> 5, 1);
      chk(im, k[0] ? int'(63.0 * $sin(ph)) : (cq + 16) >>> 5, 1);
    end
    // disabled unit keeps its results and clears its counter
    keep = p;
    run(8'h42, -ci, -cq, 0, 1'b0);
    chk(p, keep, 0);
    bus(1'b0, ADR_CTRL, 8'h00);
    chk(v, 8'h42, 0);
    // alternating sign of i: mean and last sample differ
    run(8'h43, 1024, 256, 0, 1'b1);
    chk(p, 64, 1);
    chk(re, 0, 0);
    chk(im, 8, 0);
    run(8'h41, 1024, 256, 0, 1'b1);
    chk(p, re[7] ? 118 : 10, 1);
    chk(re, re[7] ? -32 : 32, 0);
    chk(im, 8, 0);
    // 3/256 turn per 1 us sample is 500 kHz*6/256
    run(8'h63, 3000, 0, 3, 1'b0);
    chk(qf, 6, 2);
    run(8'h43, 3000, 0, 3, 1'b0);
    chk(qf, 249, 2);
    // channel changes: immediate, then held to the period boundary
    bus(1'b1, ADR_CTRL, 8'h03);
    seed = lfsr(seed);
    chan(seed[7:0]);
    @(negedge mclk_in);
    chk({7'h00, chan_apply_out}, 1, 0);
    chk(chan_number_out, int'(seed[7:0]), 0);
    bus(1'b1, ADR_CTRL, 8'h83);
    // start early in a period so both writes precede the boundary
    do begin
      bus(1'b0, ADR_CTRL, 8'h00);
    end while (v[4:2] !== 3'h1);
    chan(8'h11);
    chan(8'h5A);
    k = 0;
    while (chan_apply_out !== 1'b1 && k < 90) begin
      @(negedge mclk_in);
      k++;
    end
    chk(8'(k > 1 && k < 90), 1, 0);
    chk(chan_number_out, 8'h5A, 0);
    bus(1'b0, ADR_CTRL, 8'h00);
    chk(v, 8'h83, 0);
    final_report();
  end
endmodule : tb
`default_nettype wire
